// File: src/umrec_pkg.sv
`default_nettype none

package umrec_pkg;

  // frame offsets, byte addresses within the control frame
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_ERR_CTRL = 12'h0F0;
  localparam logic [11:0] OFF_ERR_STAT = 12'h0F8;
  localparam logic [11:0] OFF_CSU_CAP = 12'h848;
  localparam logic [11:0] OFF_BW = 12'h860;
  localparam logic [11:0] OFF_BW_CAP = 12'h868;

  // monitor readout fields
  localparam int READY_BIT = 31;
  localparam int VALUE_MSB = 30;

  // error control and error status fields
  localparam int ENABLE_BIT = 0;
  localparam int OVR_BIT = 31;
  localparam int CODE_MSB = 27;
  localparam int CODE_LSB = 24;
  localparam int GROUP_MSB = 23;
  localparam int GROUP_LSB = 16;
  localparam int ID_MSB = 15;
  localparam logic [31:0] STAT_WRITE_MASK = 32'h8FFF_FFFF;
  localparam logic [3:0] CODE_NONE = 4'h0;
  localparam logic [3:0] CODE_MON_RANGE = 4'h5;
  localparam logic [3:0] CODE_LAST = 4'h7;

  // reset values
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic ENABLE_RESET = 1'b0;

  // monitor storage: three readout kinds, each with NUM_MON entries per bank
  localparam int NUM_BANKS = 2;
  localparam int SEL_W = 8;
  localparam int IDX_W = 2;
  localparam logic [7:0] NUM_MON = 8'h04;
  localparam int SLOT_W = 4;
  localparam int SLOT_COUNT = 12;
  localparam logic [3:0] SLOT_BASE_CSU_CAP = 4'h0;
  localparam logic [3:0] SLOT_BASE_BW = 4'h4;
  localparam logic [3:0] SLOT_BASE_BW_CAP = 4'h8;

  typedef enum logic [2:0] {
    KIND_CSU_CAP = 3'b001,
    KIND_BW = 3'b010,
    KIND_BW_CAP = 3'b100
  } umrec_kind_t;

  // register access on the control frame
  typedef struct packed {
    logic valid;
    logic write;
    logic ns;
    logic [11:0] addr;
    logic [31:0] wdata;
  } umrec_req_t;

  // new reading from the counting logic
  typedef struct packed {
    logic valid;
    logic ns;
    umrec_kind_t kind;
    logic [7:0] index;
    logic ready;
    logic [30:0] value;
  } umrec_upd_t;

  // error detected elsewhere in the component
  typedef struct packed {
    logic valid;
    logic ns;
    logic [3:0] code;
    logic [7:0] group;
    logic [15:0] id;
  } umrec_err_t;

endpackage

`default_nettype wire

// File: src/umrec_store.sv
`timescale 1ns/1ps
`default_nettype none

module umrec_store (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // hardware update
  input wire logic upd_en,
  input wire logic [umrec_pkg::SLOT_W-1:0] upd_slot,
  input wire logic [31:0] upd_word,
  // software write
  input wire logic sw_en,
  input wire logic [umrec_pkg::SLOT_W-1:0] sw_slot,
  input wire logic [31:0] sw_word,
  // read
  input wire logic [umrec_pkg::SLOT_W-1:0] rd_slot,
  output logic [31:0] rd_word
);

  logic [31:0] mem [umrec_pkg::SLOT_COUNT];
  logic [31:0] next_mem [umrec_pkg::SLOT_COUNT];

  // hardware update lands after the software write, so a fresh reading is never lost
  always_comb begin
    next_mem = mem;
    if (sw_en) begin
      next_mem[sw_slot] = sw_word;
    end
    if (upd_en) begin
      next_mem[upd_slot] = upd_word;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < umrec_pkg::SLOT_COUNT; i++) begin
        mem[i] <= umrec_pkg::WORD_RESET;
      end
    end else begin
      mem <= next_mem;
    end
  end

  // slots above the last are never addressed by the owner
  assign rd_word = mem[rd_slot];

endmodule // umrec_store

`default_nettype wire

// File: src/umrec_regs.sv
`timescale 1ns/1ps
`default_nettype none

module umrec_regs #(
  parameter bit HAS_MONITORING = 1'b1,
  parameter bit HAS_CSU = 1'b1,
  parameter bit HAS_CSU_CAPTURE = 1'b1,
  parameter bit HAS_BW = 1'b1,
  parameter bit HAS_BW_CAPTURE = 1'b1,
  parameter bit CAN_ERROR = 1'b1
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RSTN,
  // control frame access
  input wire umrec_pkg::umrec_req_t REQ,
  output logic [31:0] RDATA,
  output logic ACK,
  // monitor selection, one per security bank
  input wire logic [umrec_pkg::SEL_W-1:0] MON_SEL_S,
  input wire logic [umrec_pkg::SEL_W-1:0] MON_SEL_NS,
  // counting logic and error sources
  input wire umrec_pkg::umrec_upd_t MON_UPD,
  input wire umrec_pkg::umrec_err_t ERR_IN,
  // error interrupts
  output logic IRQ_S,
  output logic IRQ_NS
);

  // a register counts as present only when every feature it depends on is present
  localparam bit CSU_CAP_ON = HAS_MONITORING & HAS_CSU & HAS_CSU_CAPTURE;
  localparam bit BW_ON = HAS_MONITORING & HAS_BW;
  localparam bit BW_CAP_ON = BW_ON & HAS_BW_CAPTURE;
  localparam logic ENABLE_RESET_C = umrec_pkg::ENABLE_RESET;

  function automatic logic [umrec_pkg::SLOT_W-1:0] slot_base(input umrec_pkg::umrec_kind_t kind);
    case (kind)
      umrec_pkg::KIND_BW: slot_base = umrec_pkg::SLOT_BASE_BW;
      umrec_pkg::KIND_BW_CAP: slot_base = umrec_pkg::SLOT_BASE_BW_CAP;
      default: slot_base = umrec_pkg::SLOT_BASE_CSU_CAP;
    endcase
  endfunction

  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic ack;
  logic next_ack;
  logic enable [umrec_pkg::NUM_BANKS];
  logic next_enable [umrec_pkg::NUM_BANKS];
  logic [31:0] stat [umrec_pkg::NUM_BANKS];
  logic [31:0] next_stat [umrec_pkg::NUM_BANKS];
  logic irq [umrec_pkg::NUM_BANKS];
  logic next_irq [umrec_pkg::NUM_BANKS];

  logic [umrec_pkg::SEL_W-1:0] sel;
  logic kind_hit;
  umrec_pkg::umrec_kind_t kind;
  logic sel_ok;
  logic mon_write;
  logic mon_range_err;
  logic [umrec_pkg::SLOT_W-1:0] acc_slot;
  logic upd_ok;
  logic [umrec_pkg::SLOT_W-1:0] upd_slot;
  logic [31:0] upd_word;
  logic [31:0] store_word [umrec_pkg::NUM_BANKS];

  // decode of the access: bank follows the security of the access
  always_comb begin
    sel = REQ.ns ? MON_SEL_NS : MON_SEL_S;
    kind = umrec_pkg::KIND_CSU_CAP;
    kind_hit = 1'b0;
    if (REQ.addr == umrec_pkg::OFF_CSU_CAP && CSU_CAP_ON) begin
      kind_hit = 1'b1;
    end else if (REQ.addr == umrec_pkg::OFF_BW && BW_ON) begin
      kind = umrec_pkg::KIND_BW;
      kind_hit = 1'b1;
    end else if (REQ.addr == umrec_pkg::OFF_BW_CAP && BW_CAP_ON) begin
      kind = umrec_pkg::KIND_BW_CAP;
      kind_hit = 1'b1;
    end
    sel_ok = sel < umrec_pkg::NUM_MON;
    // an out-of-range selector touches no monitor and is reported instead
    mon_range_err = REQ.valid && kind_hit && !sel_ok && CAN_ERROR;
    mon_write = REQ.valid && REQ.write && kind_hit && sel_ok;
    // only the low selector bits index the store; the range check guards the rest
    acc_slot = slot_base(kind) + {2'b00, sel[umrec_pkg::IDX_W-1:0]};
  end

  // readings from the counting logic, flag in the top bit
  always_comb begin
    upd_ok = MON_UPD.valid && (MON_UPD.index < umrec_pkg::NUM_MON);
    upd_slot = slot_base(MON_UPD.kind) + {2'b00, MON_UPD.index[umrec_pkg::IDX_W-1:0]};
    upd_word = {MON_UPD.ready, MON_UPD.value};
  end

  // one store per security bank keeps the two copies apart
  for (genvar b = 0; b < umrec_pkg::NUM_BANKS; b++) begin : g_bank
    umrec_store u_store (
      .clock(CLOCK),
      .rstn(RSTN),
      .upd_en(upd_ok && (MON_UPD.ns == 1'(b))),
      .upd_slot(upd_slot),
      .upd_word(upd_word),
      .sw_en(mon_write && (REQ.ns == 1'(b))),
      .sw_slot(acc_slot),
      .sw_word(REQ.wdata),
      .rd_slot(acc_slot),
      .rd_word(store_word[b])
    );
  end

  // read data and acknowledge, answered one cycle after the request
  always_comb begin
    next_ack = REQ.valid;
    // an absent register or a selector past the last monitor reads as zero
    next_rdata = umrec_pkg::WORD_RESET;
    if (REQ.valid && !REQ.write) begin
      if (kind_hit) begin
        next_rdata = sel_ok ? store_word[REQ.ns] : umrec_pkg::WORD_RESET;
      end else if (REQ.addr == umrec_pkg::OFF_ERR_CTRL && CAN_ERROR) begin
        next_rdata[umrec_pkg::ENABLE_BIT] = enable[REQ.ns];
      end else if (REQ.addr == umrec_pkg::OFF_ERR_STAT && CAN_ERROR) begin
        next_rdata = stat[REQ.ns];
      end
    end
  end

  // registered so that the answer stands one full cycle
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      rdata <= umrec_pkg::WORD_RESET;
      ack <= 1'b0;
    end else begin
      rdata <= next_rdata;
      ack <= next_ack;
    end
  end

  // error control and status per bank; a new error wins over a clearing write
  always_comb begin
    logic ext_hit;
    logic int_hit;
    logic [3:0] old_code;
    ext_hit = 1'b0;
    int_hit = 1'b0;
    old_code = umrec_pkg::CODE_NONE;
    for (int b = 0; b < umrec_pkg::NUM_BANKS; b++) begin
      next_enable[b] = enable[b];
      next_stat[b] = stat[b];
      if (REQ.valid && REQ.write && REQ.ns == b[0]) begin
        if (REQ.addr == umrec_pkg::OFF_ERR_CTRL) begin
          next_enable[b] = REQ.wdata[umrec_pkg::ENABLE_BIT];
        end
        if (REQ.addr == umrec_pkg::OFF_ERR_STAT) begin
          next_stat[b] = REQ.wdata & umrec_pkg::STAT_WRITE_MASK;
        end
      end
      // reserved codes are not recorded
      ext_hit = ERR_IN.valid && ERR_IN.ns == b[0] && ERR_IN.code != umrec_pkg::CODE_NONE
        && ERR_IN.code <= umrec_pkg::CODE_LAST;
      int_hit = mon_range_err && REQ.ns == b[0];
      old_code = next_stat[b][umrec_pkg::CODE_MSB:umrec_pkg::CODE_LSB];
      if (int_hit) begin
        // the selector error is taken as the most recent of a same-cycle pair
        next_stat[b] = {(old_code != umrec_pkg::CODE_NONE) || ext_hit, 3'b000,
          umrec_pkg::CODE_MON_RANGE, 8'h00, 8'h00, sel};
      end else if (ext_hit) begin
        next_stat[b] = {old_code != umrec_pkg::CODE_NONE, 3'b000,
          ERR_IN.code, ERR_IN.group, ERR_IN.id};
      end
      if (!CAN_ERROR) begin
        next_enable[b] = ENABLE_RESET_C;
        next_stat[b] = umrec_pkg::WORD_RESET;
      end
      // level interrupt, cleared when software clears the code
      next_irq[b] = next_enable[b]
        && next_stat[b][umrec_pkg::CODE_MSB:umrec_pkg::CODE_LSB] != umrec_pkg::CODE_NONE;
    end
  end

  // register the error state of both banks
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      for (int b = 0; b < umrec_pkg::NUM_BANKS; b++) begin
        enable[b] <= umrec_pkg::ENABLE_RESET;
        stat[b] <= umrec_pkg::WORD_RESET;
        irq[b] <= 1'b0;
      end
    end else begin
      enable <= next_enable;
      stat <= next_stat;
      irq <= next_irq;
    end
  end

  // outputs straight from flip-flops
  assign RDATA = rdata;
  assign ACK = ack;
  assign IRQ_S = irq[0];
  assign IRQ_NS = irq[1];

endmodule // umrec_regs

`default_nettype wire

// File: testbench/umrec_regs_checker.sv
`timescale 1ns/1ps
`default_nettype none

module umrec_regs_checker (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RSTN,
  // frame access and error side
  input wire umrec_pkg::umrec_req_t REQ,
  input wire logic [31:0] RDATA,
  input wire logic ACK,
  input wire umrec_pkg::umrec_err_t ERR_IN,
  input wire logic IRQ_S,
  input wire logic IRQ_NS
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  // a read of one offset, answered on the next edge
  sequence s_read(a);
    REQ.valid && !REQ.write && REQ.addr == a;
  endsequence
  a_ack_next: assert property (REQ.valid |=> ACK) else $error("ack missing");
  a_ack_cause: assert property (ACK |-> $past(REQ.valid)) else $error("stray ack");
  a_idle_zero: assert property (!ACK |-> RDATA == 32'h0000_0000) else $error("idle data");
  a_write_zero: assert property (REQ.valid && REQ.write |=> RDATA == 32'h0000_0000) else $error("write data");
  a_ctrl_rsvd: assert property (s_read(umrec_pkg::OFF_ERR_CTRL) |=> RDATA[31:1] == 31'h0)
    else $error("ctrl bits");
  a_stat_rsvd: assert property (s_read(umrec_pkg::OFF_ERR_STAT) |=> RDATA[30:28] == 3'h0)
    else $error("stat bits");
  // the interrupt level moves only on an error or an access of its own bank
  a_irqs_rise: assert property ($rose(IRQ_S) |-> $past(REQ.valid && !REQ.ns || ERR_IN.valid && !ERR_IN.ns))
    else $error("irq_s rose");
  a_irqs_fall: assert property ($fell(IRQ_S) |-> $past(REQ.valid && REQ.write && !REQ.ns))
    else $error("irq_s fell");
  a_irqn_rise: assert property ($rose(IRQ_NS) |-> $past(REQ.valid && REQ.ns || ERR_IN.valid && ERR_IN.ns))
    else $error("irq_ns rose");
  a_irqn_fall: assert property ($fell(IRQ_NS) |-> $past(REQ.valid && REQ.write && REQ.ns))
    else $error("irq_ns fell");
endmodule // umrec_regs_checker

bind umrec_regs umrec_regs_checker u_chk (.CLOCK(CLOCK), .RSTN(RSTN), .REQ(REQ), .RDATA(RDATA), .ACK(ACK),
  .ERR_IN(ERR_IN), .IRQ_S(IRQ_S), .IRQ_NS(IRQ_NS));

`default_nettype wire

// File: testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end

module testbench;
  logic clock, rstn, ack, irq_s, irq_ns;
  logic [31:0] rdata;
  logic [31:0] rdata_min;
  logic irq_min;
  logic [7:0] sel_s, sel_ns;
  umrec_pkg::umrec_req_t req;
  umrec_pkg::umrec_upd_t upd;
  umrec_pkg::umrec_err_t err;
  int n_fail = 0;
  int n_tests = 0;
  logic [11:0] offs[5] = '{umrec_pkg::OFF_ERR_CTRL, umrec_pkg::OFF_ERR_STAT, umrec_pkg::OFF_CSU_CAP,
    umrec_pkg::OFF_BW, umrec_pkg::OFF_BW_CAP};

  umrec_regs u_dut (.CLOCK(clock), .RSTN(rstn), .REQ(req), .RDATA(rdata), .ACK(ack), .MON_SEL_S(sel_s),
    .MON_SEL_NS(sel_ns), .MON_UPD(upd), .ERR_IN(err), .IRQ_S(irq_s), .IRQ_NS(irq_ns));

  // second copy with no bandwidth monitors and no error conditions, fed the same traffic
  umrec_regs #(.HAS_BW(1'b0), .CAN_ERROR(1'b0)) u_dut_min (.CLOCK(clock), .RSTN(rstn), .REQ(req),
    .RDATA(rdata_min), .ACK(), .MON_SEL_S(sel_s), .MON_SEL_NS(sel_ns), .MON_UPD(upd), .ERR_IN(err),
    .IRQ_S(irq_min), .IRQ_NS());

  // 50 MHz system clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // one access: strobe for one edge, data taken while the ack stands after the taking edge
  task automatic acc(input logic w, input logic ns, input logic [11:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge clock);
    req <= '{1'b1, w, ns, a, wd};
    @(posedge clock);
    req.valid <= 1'b0;
    #1;
    `CHK("ack", 1'b1, ack)
    rd = rdata;
  endtask

  task automatic wr(input logic ns, input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    acc(1'b1, ns, a, d, x);
  endtask

  task automatic rd_chk(input logic ns, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    acc(1'b0, ns, a, 32'h0, d);
    `CHK("rdata", e, d)
  endtask

  // counting logic hands in a reading for monitor 2
  task automatic mon(input logic ns, input logic [2:0] k, input logic [31:0] w);
    @(posedge clock);
    upd <= '{1'b1, ns, umrec_pkg::umrec_kind_t'(k), 8'h02, w[31], w[30:0]};
    @(posedge clock);
    upd.valid <= 1'b0;
  endtask

  task automatic fault(input logic ns, input logic [3:0] c);
    @(posedge clock);
    err <= '{1'b1, ns, c, 8'h03, 16'h0009};
    @(posedge clock);
    err.valid <= 1'b0;
    #1;
  endtask

  // every register of both banks starts at zero, as does an unmapped offset
  task automatic t_reset;
    foreach (offs[i]) begin
      rd_chk(1'b0, offs[i], 32'h0);
      rd_chk(1'b1, offs[i], 32'h0);
    end
    rd_chk(1'b0, 12'h004, 32'h0);
  endtask

  // the banks keep apart, ready flag passes through, selector routes
  task automatic t_monitor;
    for (int k = 0; k < 3; k++) begin
      mon(1'b1, 3'h1 << k, 32'h8000_0005 + k);
      mon(1'b0, 3'h1 << k, 32'h0000_0011 + k);
      rd_chk(1'b1, offs[k+2], 32'h8000_0005 + k);
      rd_chk(1'b0, offs[k+2], 32'h0000_0011 + k);
    end
    @(posedge clock);
    sel_s <= 8'h01;
    sel_ns <= 8'h01;
    wr(1'b0, umrec_pkg::OFF_BW, 32'h1234_5678);
    rd_chk(1'b0, umrec_pkg::OFF_BW, 32'h1234_5678);
    rd_chk(1'b1, umrec_pkg::OFF_BW, 32'h0);
  endtask

  // error capture, overwrite, clearing and interrupt gating
  task automatic t_error;
    wr(1'b0, umrec_pkg::OFF_ERR_CTRL, 32'hFFFF_FFFF);
    rd_chk(1'b0, umrec_pkg::OFF_ERR_CTRL, 32'h1);
    fault(1'b0, 4'h2);
    `CHK("irq_s", 1'b1, irq_s)
    `CHK("irq_ns", 1'b0, irq_ns)
    rd_chk(1'b0, umrec_pkg::OFF_ERR_STAT, 32'h0203_0009);
    fault(1'b0, 4'h8);
    rd_chk(1'b0, umrec_pkg::OFF_ERR_STAT, 32'h0203_0009);
    fault(1'b0, 4'h7);
    rd_chk(1'b0, umrec_pkg::OFF_ERR_STAT, 32'h8703_0009);
    wr(1'b0, umrec_pkg::OFF_ERR_STAT, 32'h0);
    `CHK("irq_s", 1'b0, irq_s)
    // second bank has its enable clear: codes 1 to 7 each recorded, no interrupt
    for (int c = 1; c < 8; c++) begin
      fault(1'b1, c[3:0]);
      `CHK("irq_ns", 1'b0, irq_ns)
      rd_chk(1'b1, umrec_pkg::OFF_ERR_STAT, {c > 1, 3'h0, c[3:0], 24'h03_0009});
    end
    @(posedge clock);
    sel_s <= 8'h04;
    rd_chk(1'b0, umrec_pkg::OFF_CSU_CAP, 32'h0);
    rd_chk(1'b0, umrec_pkg::OFF_ERR_STAT, 32'h0500_0004);
    `CHK("irq_s", 1'b1, irq_s)
  endtask

  // the reduced copy reads zero for absent registers and never records an error
  task automatic t_absent;
    logic [31:0] d;
    @(posedge clock);
    sel_s <= 8'h02;
    wr(1'b0, umrec_pkg::OFF_ERR_CTRL, 32'h1);
    mon(1'b0, 3'h2, 32'h8000_0009);
    fault(1'b0, 4'h3);
    `CHK("min irq", 1'b0, irq_min)
    acc(1'b0, 1'b0, umrec_pkg::OFF_ERR_STAT, 32'h0, d);
    `CHK("min stat", 32'h0, rdata_min)
    acc(1'b0, 1'b0, umrec_pkg::OFF_ERR_CTRL, 32'h0, d);
    `CHK("min ctrl", 32'h0, rdata_min)
    acc(1'b0, 1'b0, umrec_pkg::OFF_BW, 32'h0, d);
    `CHK("min bw", 32'h0, rdata_min)
    `CHK("bw", 32'h8000_0009, d)
  endtask

  initial begin
    rstn = 1'b0;
    req = '0;
    upd = '0;
    err = '0;
    sel_s = 8'h02;
    sel_ns = 8'h02;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    t_reset;
    t_monitor;
    t_error;
    t_absent;
    give_verdict;
  end

  // hang guard, well past the roughly 120 cycles the run needs
  initial begin
    repeat (3000) @(posedge clock);
    n_fail++;
    give_verdict;
  end
endmodule // testbench

`default_nettype wire
